//--- design/touch_link_pkg.sv
// Package with command layout, power modes, channel codes and link timing for the touch converter link.
package touch_link_pkg;

   // ----------------------------------------------------------------------
   // Command byte layout
   // ----------------------------------------------------------------------
   localparam int CMD_BITS          = 8;   // Command length in bits.
   localparam int CMD_START_POS     = 7;   // Start bit position.
   localparam int CHAN_HI_POS       = 6;   // Channel select upper bit.
   localparam int CHAN_LO_POS       = 4;   // Channel select lower bit.
   localparam int RES_POS           = 3;   // Resolution bit, high means 8-bit result.
   localparam int SINGLE_ENDED_POS  = 2;   // Single-ended select bit.
   localparam int REF_POWER_POS     = 1;   // Reference power bit.
   localparam int CONV_POWER_POS    = 0;   // Converter power bit.

   // ----------------------------------------------------------------------
   // Channel codes
   // ----------------------------------------------------------------------
   localparam logic [2:0] CHAN_TEMP0 = 3'h0;  // First temperature diode.
   localparam logic [2:0] CHAN_Y     = 3'h1;  // Y axis position.
   localparam logic [2:0] CHAN_BATT  = 3'h2;  // Battery monitor.
   localparam logic [2:0] CHAN_Z1    = 3'h3;  // First pressure measurement.
   localparam logic [2:0] CHAN_Z2    = 3'h4;  // Second pressure measurement.
   localparam logic [2:0] CHAN_X     = 3'h5;  // X axis position.
   localparam logic [2:0] CHAN_AUX   = 3'h6;  // Auxiliary input.
   localparam logic [2:0] CHAN_TEMP1 = 3'h7;  // Second temperature diode.

   // ----------------------------------------------------------------------
   // Edge numbers within a frame (counted from one)
   // ----------------------------------------------------------------------
   localparam logic [5:0] REF_UPDATE_RISE   = 6'h07;  // Reference power latched here.
   localparam logic [5:0] CONV_UPDATE_RISE  = 6'h08;  // Converter power latched here.
   localparam logic [5:0] HOLD_END_RISE     = 6'h05;  // Held switches released here.
   localparam logic [5:0] TRACK_START_FALL  = 6'h05;  // Tracking opens.
   localparam logic [5:0] TRACK_END_FALL    = 6'h08;  // Tracking closes, busy rises.
   localparam logic [5:0] BUSY_END_FALL     = 6'h09;  // Busy falls, first result bit.
   localparam logic [5:0] DIFF_END_FALL     = 6'h14;  // Differential drive ends (twentieth).
   localparam logic [5:0] OVERLAP_PERIOD    = 6'h0F;  // Earliest rising edge for an overlapped start bit (14 clocks after the first).

   // ----------------------------------------------------------------------
   // Result widths and reset values
   // ----------------------------------------------------------------------
   localparam int RESULT_BITS_FULL  = 12;       // Full resolution result.
   localparam int RESULT_BITS_SHORT = 8;        // Short resolution result.
   localparam logic [1:0] POWER_RESET = 2'h0;   // Power bits after reset.

   // ----------------------------------------------------------------------
   // Host timing
   // ----------------------------------------------------------------------
   localparam int SCLK_DIV_HALF = 4;            // System clocks per serial clock half period.

endpackage : touch_link_pkg

//--- design/touch_link_if.sv
// Interface carrying the four-wire serial link, the busy flag and their output enables between host and converter.
`timescale 1ns/1ps
interface touch_link_if;
   logic chip_select_n;   // Frame select from host, active low.
   logic serial_clock;    // Serial clock made by host.
   logic data_in;         // Command bits to the converter.
   logic data_out;        // Result bits from the converter.
   logic data_out_oe;     // High while the converter drives data_out.
   logic busy;            // Converter busy flag.
   logic busy_oe;         // High while the converter drives busy.

   // Host end.
   modport host (
      output chip_select_n,
      output serial_clock,
      output data_in,
      input  data_out,
      input  data_out_oe,
      input  busy,
      input  busy_oe
   );

   // Converter end.
   modport device (
      input  chip_select_n,
      input  serial_clock,
      input  data_in,
      output data_out,
      output data_out_oe,
      output busy,
      output busy_oe
   );
endinterface : touch_link_if

//--- design/touch_link_host.sv
// Host end: APB-driven serial master that sends one command and collects one result.
`timescale 1ns/1ps
module touch_link_host
   import touch_link_pkg::*;
#(
   parameter int DIV_HALF = SCLK_DIV_HALF  // System clocks per serial clock half period.
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   touch_link_if.host       link
);

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [11:0] CMD_OFF    = 12'h000;  // Write while idle starts a frame with the low byte.
   localparam logic [11:0] STATUS_OFF = 12'h004;  // Bit 0 running, bit 1 done.
   localparam logic [11:0] RESULT_OFF = 12'h008;  // Last result, right aligned.
   localparam logic [5:0]  FRAME_CLKS = 6'h18;    // Serial clocks per frame (24).

   logic [7:0]  cmd;        // Command being sent.
   logic [15:0] shift_in;   // Result bits collected.
   logic [11:0] result;     // Last result.
   logic        running;    // Frame in progress.
   logic        done;       // Result available, cleared on a new command.
   logic [5:0]  clk_num;    // Serial clocks completed.
   logic [7:0]  div;        // Half period divider.
   logic        sclk;       // Serial clock level.

   // ----------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------
   wire access   = psel && penable;
   wire cmd_wr   = access && pwrite && (paddr == CMD_OFF) && !running;
   wire half_end = running && (div == 8'(DIV_HALF - 1));
   wire mapped   = (paddr == CMD_OFF) || (paddr == STATUS_OFF) || (paddr == RESULT_OFF);

   assign pready  = 1'b1;            // Every access completes in its first access cycle.
   assign pslverr = access && !mapped;
   assign prdata  = (paddr == STATUS_OFF) ? {30'h0000_0000, done, running} :
                    (paddr == RESULT_OFF) ? {20'h0_0000, result} : 32'h0000_0000;

   // Command bits leave MSB first, start bit in front, then the line stays low.
   assign link.chip_select_n = !running;
   assign link.serial_clock  = sclk;
   assign link.data_in       = running && (clk_num < 6'(CMD_BITS)) && cmd[3'(7 - clk_num)];

   // ----------------------------------------------------------------------
   // Frame sequencer: data changes on falling edges, result sampled on rising.
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd      <= 8'h00;
         running  <= 1'b0;
         done     <= 1'b0;
         clk_num  <= 6'h00;
         div      <= 8'h00;
         sclk     <= 1'b0;
         shift_in <= 16'h0000;
         result   <= 12'h000;
      end else if (cmd_wr) begin
         cmd     <= pwdata[7:0] | 8'h80;  // Start bit forced to one.
         running <= 1'b1;
         done    <= 1'b0;
         clk_num <= 6'h00;
         div     <= 8'h00;
         sclk    <= 1'b0;
      end else if (half_end) begin
         div <= 8'h00;
         sclk <= !sclk;
         if (!sclk) begin
            shift_in <= {shift_in[14:0], link.data_out};
         end else if (clk_num == FRAME_CLKS - 6'h01) begin
            running <= 1'b0;
            done    <= 1'b1;
            result <= cmd[RES_POS] ? {4'h0, shift_in[14:7]} : shift_in[14:3];
         end else begin
            clk_num <= clk_num + 6'h01;
         end
      end else if (running) begin
         div <= div + 8'h01;
      end
   end

endmodule : touch_link_host

//--- design/touch_link_device.sv
// Converter end: command capture, power modes, plate switches, pen interrupt gating and result shifting.
`timescale 1ns/1ps
module touch_link_device
   import touch_link_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   touch_link_if.device     link,
   input  wire logic [11:0] sample,          // Converted value from the analog core.
   input  wire logic        pen_touched,     // Plate contact level from the analog core.
   output logic             x_plus_drive,    // X-plus plate switch closed.
   output logic             x_minus_drive,   // X-minus plate switch closed.
   output logic             y_plus_drive,    // Y-plus plate switch closed.
   output logic             y_minus_pin,     // Y-minus switch closed, pin tied to ground.
   output logic             converter_on,    // Converter powered.
   output logic             reference_on,    // Internal reference powered.
   output logic             tracking,        // Input tracking window.
   output logic [2:0]       channel_select,  // Converter input choice.
   output logic             single_ended_select,  // Measurement mode of the current command.
   output logic             touch_irq_n      // Pen interrupt output, active low.
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [1:0] cs_sync;    // Chip select pair.
   logic [1:0] clk_sync;   // Serial clock pair.
   logic [1:0] din_sync;   // Data input pair.
   logic       clk_last;   // Previous synchronised clock for edge finding.
   logic       cs_last;    // Previous synchronised select.

   // Two flip-flops on each link pin; edges are found on the second stage only.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_sync  <= 2'h3;  // Deselected level.
         clk_sync <= 2'h0;
         din_sync <= 2'h0;
         clk_last <= 1'b0;  // Matches the idle clock, so no false edge follows reset.
         cs_last  <= 1'b1;
      end else begin
         cs_sync  <= {cs_sync[0], link.chip_select_n};
         clk_sync <= {clk_sync[0], link.serial_clock};
         din_sync <= {din_sync[0], link.data_in};
         clk_last <= clk_sync[1];
         cs_last  <= cs_sync[1];
      end
   end

   wire selected = !cs_sync[1];
   wire cs_fall  = cs_last && !cs_sync[1];
   wire rise     = selected && clk_sync[1] && !clk_last;
   wire fall     = selected && !clk_sync[1] && clk_last;

   // ----------------------------------------------------------------------
   // Command state
   // ----------------------------------------------------------------------
   logic       started;     // Start bit seen in this command.
   logic [5:0] rise_num;    // Rising edges since start bit (start bit is one).
   logic [5:0] fall_num;    // Falling edges since start bit.
   logic [6:0] cmd_sr;      // Command bits after the start bit.
   logic [7:0] cmd;         // Latched command byte.
   logic       ref_bit;     // Reference power state.
   logic       conv_bit;    // Converter power state.
   logic       prev_xy;     // Previous command chose an axis channel.
   logic [11:0] out_sr;     // Result shift register.
   logic       out_bit;     // Registered data output.
   logic       busy_q;      // Registered busy.

   function automatic logic is_axis(input logic [2:0] ch);
      is_axis = (ch == CHAN_X) || (ch == CHAN_Y);
   endfunction

   function automatic logic is_plate(input logic [2:0] ch);
      is_plate = is_axis(ch) || (ch == CHAN_Z1) || (ch == CHAN_Z2);
   endfunction

   // Start bit on a rising edge begins counting; counter restarts on select fall.
   wire start_now = rise && !started && din_sync[1];
   wire cmd_done  = rise && started && (rise_num == CONV_UPDATE_RISE - 6'h01);
   // A new start bit may arrive during result shifting for overlapped frames.
   wire restart   = rise && started && (rise_num >= OVERLAP_PERIOD - 6'h01) && din_sync[1];

   // Command sequencer: counts edges from the start bit, shifts the command in, latches power bits.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         started  <= 1'b0;
         rise_num <= 6'h00;
         fall_num <= 6'h00;
         cmd_sr   <= 7'h00;
         cmd      <= 8'h00;
         ref_bit  <= POWER_RESET[1];
         conv_bit <= POWER_RESET[0];
         prev_xy  <= 1'b0;
      end else if (cs_fall || !selected) begin
         // Power bits and the last command survive a deselect; only the framing restarts.
         started  <= 1'b0;
         rise_num <= 6'h00;
         fall_num <= 6'h00;
      end else if (start_now || restart) begin
         started  <= 1'b1;
         rise_num <= 6'h01;
         fall_num <= 6'h00;
         cmd_sr   <= 7'h00;
         prev_xy  <= is_axis(cmd[CHAN_HI_POS:CHAN_LO_POS]);
      end else if (rise && started) begin
         if (rise_num < 6'(CMD_BITS)) cmd_sr <= {cmd_sr[5:0], din_sync[1]};
         if (rise_num != 6'h3F) rise_num <= rise_num + 6'h01;
         // The reference bit is the one on the line at rising edge seven, not yet in the shifter.
         if (rise_num == REF_UPDATE_RISE - 6'h01) ref_bit <= din_sync[1];
         if (cmd_done) begin
            cmd <= {1'b1, cmd_sr[5:0], din_sync[1]};
            conv_bit <= din_sync[1];
         end
      end else if (fall && started && fall_num != 6'h3F) begin
         fall_num <= fall_num + 6'h01;
      end
   end

   // Channel bits become visible on rising edge four, before tracking begins. While the command
   // is still shifting in they move up one place per edge, so the shifter is realigned by the
   // edge count; from edge eight on the latched command holds them.
   wire [6:0] chan_shift = cmd_sr >> (rise_num - 6'h04);  // Channel bits brought to the bottom.
   wire       shifting   = (rise_num >= 6'h04) && (rise_num < CONV_UPDATE_RISE);
   wire [2:0] live_chan  = shifting ? chan_shift[2:0] : cmd[CHAN_HI_POS:CHAN_LO_POS];
   // The measurement mode bit arrives at edge six and sits one place higher at edge seven.
   wire       live_se    = (rise_num == 6'h06) ? cmd_sr[0] :
                           (rise_num == 6'h07) ? cmd_sr[1] : cmd[SINGLE_ENDED_POS];
   wire       track_win = started && fall_num >= TRACK_START_FALL && fall_num < TRACK_END_FALL;
   wire       conv_win  = started && fall_num >= TRACK_START_FALL && fall_num < DIFF_END_FALL;
   wire       held      = conv_bit && (!started || rise_num < HOLD_END_RISE);
   wire       drive_now = is_plate(live_chan) && (live_se ? track_win : conv_win);
   wire       mode01    = conv_bit && is_axis(live_chan) && selected;
   wire       plates_on = selected && (held ? is_plate(cmd[CHAN_HI_POS:CHAN_LO_POS]) : (drive_now || mode01));
   wire [2:0] sw_chan   = held ? cmd[CHAN_HI_POS:CHAN_LO_POS] : live_chan;

   // ----------------------------------------------------------------------
   // Outputs: result shifting and busy
   // ----------------------------------------------------------------------
   wire fall_busy  = fall && started && (fall_num == TRACK_END_FALL - 6'h01);
   wire fall_first = fall && started && (fall_num == BUSY_END_FALL - 6'h01);

   // Result shifter and busy flag; both move on falling serial edges and clear on a deselect.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q  <= 1'b0;
         out_bit <= 1'b0;
         out_sr  <= 12'h000;
      end else if (cs_fall || !selected) begin
         busy_q  <= 1'b0;
         out_bit <= 1'b0;
         out_sr  <= 12'h000;
      end else if (fall_busy) begin
         busy_q <= 1'b1;
         out_sr <= cmd[RES_POS] ? {sample[11:4], 4'h0} : sample;
      end else if (fall_first) begin
         busy_q <= 1'b0;
         out_bit <= out_sr[11];
         out_sr  <= {out_sr[10:0], 1'b0};
      end else if (fall && started && fall_num > BUSY_END_FALL - 6'h01) begin
         out_bit <= out_sr[11];
         out_sr  <= {out_sr[10:0], 1'b0};
      end
   end

   assign link.busy        = busy_q;
   assign link.busy_oe     = selected;
   assign link.data_out    = out_bit;
   assign link.data_out_oe = selected;

   // ----------------------------------------------------------------------
   // Plate switches, power and pen interrupt
   // ----------------------------------------------------------------------
   assign x_plus_drive  = plates_on && (sw_chan == CHAN_X);
   assign x_minus_drive = plates_on && (sw_chan == CHAN_X || sw_chan == CHAN_Z1 || sw_chan == CHAN_Z2);
   assign y_plus_drive  = plates_on && (sw_chan == CHAN_Y || sw_chan == CHAN_Z1 || sw_chan == CHAN_Z2);
   assign y_minus_pin   = !selected || (plates_on && sw_chan == CHAN_Y);
   assign reference_on  = ref_bit;
   assign converter_on  = conv_bit ? (ref_bit || selected) : conv_win;
   assign tracking      = track_win;
   assign channel_select      = live_chan;
   assign single_ended_select = live_se;

   // Interrupt: disabled in mode 11 when deselected; forced during conversion window per channel.
   wire irq_pen  = !pen_touched;
   wire irq_live = conv_win ? !is_axis(live_chan) : irq_pen;
   wire irq_hold = prev_xy ? 1'b0 : 1'b1;
   assign touch_irq_n = (ref_bit && conv_bit && !selected) ? 1'b1 :
                        (conv_bit && selected && !conv_win) ? (held ? irq_hold : !is_axis(live_chan)) :
                        irq_live;

endmodule : touch_link_device

//--- verif/touch_link_chk.sv
// Checker for the serial link between the host end and the converter end.
`timescale 1ns/1ps
module touch_link_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic chip_select_n,
   input wire logic serial_clock,
   input wire logic data_in,
   input wire logic data_out,
   input wire logic data_out_oe,
   input wire logic busy,
   input wire logic busy_oe
);
   // --------------------------------------------------------------
   // Serial clock edge counting within a frame
   // --------------------------------------------------------------
   logic       sclk_q;      // Serial clock one cycle ago.
   logic [4:0] falls;       // Falling edges seen in this frame.
   logic [4:0] rises;       // Rising edges seen in this frame.
   logic [3:0] since_fall;  // Cycles since the last falling edge, saturating.
   wire  logic fall_seen = sclk_q & ~serial_clock;
   wire  logic rise_seen = ~sclk_q & serial_clock;

   // Edge counts restart whenever the frame is closed, so each frame numbers its own edges.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q     <= 1'b0;
         falls      <= 5'h0;
         rises      <= 5'h0;
         since_fall <= 4'h0;
      end else begin
         sclk_q     <= serial_clock;
         falls      <= chip_select_n ? 5'h0 : falls + 5'(fall_seen);
         rises      <= chip_select_n ? 5'h0 : rises + 5'(rise_seen);
         since_fall <= fall_seen ? 4'h0 : since_fall + 4'(since_fall != 4'hF);
      end
   end

   // --------------------------------------------------------------
   // Properties
   // --------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence busy_pulse;
      busy [*8] ##1 !busy;
   endsequence

   sel_drive_a: assert property ($fell(chip_select_n) |->
      ##[1:4] (busy_oe && data_out_oe && !busy && !data_out)) else $error("Link outputs not driven low.");
   busy_start_a: assert property ($rose(busy) |-> falls == 5'h08)
      else $error("Busy rose at the wrong edge.");
   busy_width_a: assert property ($rose(busy) |-> busy_pulse)
      else $error("Busy not one serial clock wide.");
   busy_end_a: assert property ($fell(busy) && !chip_select_n |-> falls == 5'h09)
      else $error("Busy fell at the wrong edge.");
   data_quiet_a: assert property (!chip_select_n && data_out_oe && falls < 5'h09 |-> !data_out)
      else $error("Result data before the ninth falling edge.");
   data_step_a: assert property (!chip_select_n && data_out_oe && $past(data_out_oe) && $changed(data_out) |->
      since_fall <= 4'h4) else $error("Result bit changed away from a falling edge.");
   hold_low_a: assert property (rise_seen && rises >= 5'h08 && rises <= 5'h0E |-> !data_in)
      else $error("Data input high during the result clocks.");
   bit_stable_a: assert property (rise_seen && !chip_select_n |-> $stable(data_in))
      else $error("Data input moved at a sampling edge.");
   sel_release_a: assert property ($rose(chip_select_n) |-> ##[1:4] (!busy_oe && !data_out_oe))
      else $error("Link outputs still driven after select rise.");
   busy_seen_c: cover property ($rose(busy));
endmodule : touch_link_chk

//--- verif/testbench.sv
// Self-checking bench joining the host end and the converter end over the serial link.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; $display("ERROR t=%0t got %0h want %0h", $time, (a), (b)); end end
module testbench;
   import touch_link_pkg::*;
   // One row: command, converter sample, pen level, and drive/interrupt expectations.
   typedef struct packed {logic [7:0] cmd; logic [11:0] samp; logic pen; logic [5:0] exp;} row_t;
   localparam row_t ROWS [5] = '{'{8'hD4, 12'hA5C, 1'b1, 6'h10}, '{8'hDA, 12'hFFF, 1'b0, 6'h19},
      '{8'h87, 12'h001, 1'b1, 6'h03}, '{8'hD5, 12'h800, 1'b1, 6'h1C}, '{8'h84, 12'h7FE, 1'b0, 6'h23}};
   logic        pclk, presetn, psel, penable, pwrite, pen_touched, sclk_q, prev_ref, err;
   logic [11:0] paddr, sample, wres;
   logic [31:0] pwdata, rd;
   logic [4:0]  nf, nr;
   logic [7:0]  rec [0:31];  // Converter outputs seen at each falling serial edge.
   logic [31:0] prdata;
   logic        pready, pslverr, x_plus_drive, x_minus_drive, y_plus_drive, y_minus_pin;
   logic        converter_on, reference_on, tracking, single_ended_select, touch_irq_n;
   logic [2:0]  channel_select;
   logic [11:0] exp_res;
   int          bad_count = 0, checks = 0;
   wire  logic [7:0] dev_vec = {touch_irq_n, converter_on, reference_on, tracking,
                                x_plus_drive, x_minus_drive, y_plus_drive, y_minus_pin};

   touch_link_if touch_link_if_i ();
   touch_link_host #(.DIV_HALF(SCLK_DIV_HALF)) touch_link_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(touch_link_if_i));
   touch_link_device touch_link_device_i (.pclk(pclk), .presetn(presetn), .link(touch_link_if_i),
      .sample(sample), .pen_touched(pen_touched), .x_plus_drive(x_plus_drive), .x_minus_drive(x_minus_drive),
      .y_plus_drive(y_plus_drive), .y_minus_pin(y_minus_pin), .converter_on(converter_on),
      .reference_on(reference_on), .tracking(tracking), .channel_select(channel_select),
      .single_ended_select(single_ended_select), .touch_irq_n(touch_irq_n));
   touch_link_chk touch_link_chk_i (.pclk(pclk), .presetn(presetn), .chip_select_n(touch_link_if_i.chip_select_n),
      .serial_clock(touch_link_if_i.serial_clock), .data_in(touch_link_if_i.data_in),
      .data_out(touch_link_if_i.data_out), .data_out_oe(touch_link_if_i.data_out_oe),
      .busy(touch_link_if_i.busy), .busy_oe(touch_link_if_i.busy_oe));

   // Clock of 50 ns period.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Records converter outputs at each falling serial edge and result bits at rising edges ten to twenty-one.
   always @(posedge pclk) begin
      sclk_q <= touch_link_if_i.serial_clock;
      if (touch_link_if_i.chip_select_n !== 1'b0) begin
         nf <= 5'h0;
         nr <= 5'h0;
      end else if (sclk_q && !touch_link_if_i.serial_clock) begin
         nf          <= nf + 5'h1;
         rec[nf + 1] <= dev_vec;
      end else if (!sclk_q && touch_link_if_i.serial_clock) begin
         nr <= nr + 5'h1;
         if (nr >= 5'h09 && nr <= 5'h14) wres <= {wres[10:0], touch_link_if_i.data_out};
      end
   end

   // Prints the counts and the verdict, then stops.
   task automatic complete_run();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // One APB transfer; read data and error flag are taken at the completing edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin bad_count++; complete_run(); end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   // Main sequence: reset, table of frames, then the unmapped access.
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000;
      sample = 12'h000; pen_touched = 1'b0; prev_ref = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK({y_minus_pin, reference_on, x_plus_drive}, 3'h4)
      for (int i = 0; i < 5; i++) begin
         sample <= ROWS[i].samp;
         pen_touched <= ROWS[i].pen;
         exp_res = ROWS[i].cmd[3] ? {ROWS[i].samp[11:4], 4'h0} : ROWS[i].samp;
         apb(1'b1, 12'h000, {24'h00_0000, ROWS[i].cmd});
         apb(1'b0, 12'h004, 32'h0000_0000);
         `CHK(rd[0], 1'b1)
         for (int n = 0; n <= 200 && rd[1] !== 1'b1; n++) begin
            if (n == 200) begin bad_count++; complete_run(); end
            apb(1'b0, 12'h004, 32'h0000_0000);
         end
         repeat (4) @(posedge pclk);
         `CHK(wres, exp_res)
         apb(1'b0, 12'h008, 32'h0000_0000);
         `CHK(rd[11:0], ROWS[i].cmd[3] ? {4'h0, ROWS[i].samp[11:4]} : ROWS[i].samp)
         `CHK({rec[5][4], rec[6][4], rec[8][4], rec[9][4]}, 4'h6)
         `CHK({rec[3][3], rec[7][3], rec[12][3], rec[22][3]}, ROWS[i].exp[5:2])
         `CHK(rec[12][7], ROWS[i].exp[1])
         `CHK({rec[6][5], rec[7][5]}, {prev_ref, ROWS[i].cmd[1]})
         if (ROWS[i].cmd[0]) `CHK(rec[22][6], 1'b1)
         `CHK({x_plus_drive, x_minus_drive, y_plus_drive, y_minus_pin}, 4'h1)
         `CHK(reference_on, ROWS[i].cmd[1])
         if (ROWS[i].cmd[1:0] != 2'h1) `CHK(converter_on, ROWS[i].cmd[1:0] == 2'h3)
         `CHK(touch_irq_n, ROWS[i].exp[0])
         `CHK({channel_select, single_ended_select}, {ROWS[i].cmd[6:4], ROWS[i].cmd[2]})
         prev_ref = ROWS[i].cmd[1];
      end
      apb(1'b0, 12'hFFC, 32'h0000_0000);
      `CHK(err, 1'b1)
      complete_run();
   end
endmodule : testbench
